// ===== common/seq_pkg.sv
package seq_pkg;
   // field widths shared by the player and its helpers
   localparam int ADDR_W = 16;
   localparam int CNT_W = 16;
   localparam int SAMP_W = 16;
   localparam int GRP_W = 4;
   localparam int PTR_W = 5;
   localparam int PAR_W = 32;
   localparam int AMP_W = 16;
   // shortest idle pause in samples, and the unit loop count
   localparam logic [CNT_W-1:0] IDLE_MIN_LEN = 16'h000A;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   typedef enum logic [1:0] {ET_DATA, ET_CONFIG, ET_IDLE, ET_EMPTY} etype_t;
   typedef enum logic [1:0] {ADV_AUTO, ADV_COND, ADV_REPEAT, ADV_SINGLE} adv_t;
   typedef enum logic [1:0] {DEC_REPLAY, DEC_WAIT_REPLAY, DEC_WAIT_NEXT, DEC_NEXT} dec_t;
   typedef enum logic [3:0] {
      ACT_PHASE_ADD, ACT_PHASE_BUMP, ACT_PHASE_FORCE, ACT_RAMP_RATE, ACT_RAMP_RESTART,
      ACT_RAMP_GO, ACT_RAMP_STOP, ACT_TONE_SET, ACT_GAIN_SET
   } act_kind_t;

   // one sequence table entry, most significant field first
   typedef struct packed {
      etype_t etype;
      logic new_seq;
      logic [ADDR_W-1:0] seg_addr;
      logic [ADDR_W-1:0] start_off;
      logic [ADDR_W-1:0] end_off;
      logic [CNT_W-1:0] seg_loop;
      adv_t seg_adv;
      logic [CNT_W-1:0] seq_loop;
      adv_t seq_adv;
      logic amp_init;
      logic amp_next;
      logic freq_init;
      logic freq_next;
      logic [GRP_W-1:0] action_group_id;
      logic [CNT_W-1:0] idle_delay;
      logic [SAMP_W-1:0] idle_sample;
   } entry_t;
   localparam int ENTRY_W = $bits(entry_t);

   // one action table row
   typedef struct packed {
      logic en;
      logic [GRP_W-1:0] grp;
      act_kind_t kind;
      logic [PAR_W-1:0] param;
   } act_t;
   localparam int ACT_W = $bits(act_t);

   typedef struct packed {
      dec_t dec;
      logic used;
      logic [CNT_W-1:0] left;
   } dec_res_t;

   // end of one pass: what to do next given mode, passes left and pending event
   function automatic dec_res_t adv_decide(adv_t mode, logic [CNT_W-1:0] cnt, logic ev);
      dec_res_t r;
      r.left = (cnt > CNT_ONE) ? CNT_W'(cnt - CNT_ONE) : '0;
      r.used = 1'b0;
      case (mode)
         ADV_AUTO: r.dec = (r.left != '0) ? DEC_REPLAY : DEC_NEXT;
         ADV_COND: begin
            r.left = cnt;
            r.used = ev;
            r.dec = ev ? DEC_NEXT : DEC_REPLAY;
         end
         ADV_REPEAT: r.dec = (r.left != '0) ? DEC_REPLAY : DEC_WAIT_NEXT;
         ADV_SINGLE: r.dec = (r.left != '0) ? DEC_WAIT_REPLAY : DEC_NEXT;
         default: r.dec = DEC_NEXT;
      endcase
      return r;
   endfunction : adv_decide
endpackage : seq_pkg

// ===== src/seq_out_buffer.sv
`timescale 1ns/1ns
module seq_out_buffer import seq_pkg::*; #(
   parameter int W = SAMP_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   typedef struct packed {
      logic [1:0] cnt;
      logic [W-1:0] d0;
      logic [W-1:0] d1;
   } buf_state_t;
   buf_state_t s_r, s_nxt;
   logic push, pop;
   logic [1:0] slot;

   // two slots, head in d0; full blocks the producer
   always_comb begin
      s_nxt = s_r;
      pop = (s_r.cnt != 2'h0) && out_ready;
      push = in_valid && (s_r.cnt != 2'h2);
      slot = s_r.cnt - {1'b0, pop};
      if (pop) s_nxt.d0 = s_r.d1;
      if (push && slot == 2'h0) s_nxt.d0 = in_data;
      if (push && slot == 2'h1) s_nxt.d1 = in_data;
      s_nxt.cnt = slot + {1'b0, push};
   end

   always_ff @(posedge ref_clk) begin
      if (rst) s_r <= '0;
      else s_r <= s_nxt;
   end

   assign in_ready = (s_r.cnt != 2'h2);
   assign out_valid = (s_r.cnt != 2'h0);
   assign out_data = s_r.d0;
endmodule : seq_out_buffer

// ===== src/seq_action_unit.sv
`timescale 1ns/1ns
module seq_action_unit import seq_pkg::*; #(
   parameter int ACT_DEPTH = 16,
   parameter int AIDX_W = $clog2(ACT_DEPTH)
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic fire,
   input wire logic [GRP_W-1:0] fire_grp,
   input wire logic act_wr_en,
   input wire logic [AIDX_W-1:0] act_wr_addr,
   input wire logic [ACT_W-1:0] act_wr_data,
   output logic busy,
   output logic [PAR_W-1:0] phase_offset,
   output logic phase_bump_stb,
   output logic [PAR_W-1:0] phase_bump,
   output logic phase_force_stb,
   output logic [PAR_W-1:0] phase_force,
   output logic [PAR_W-1:0] ramp_rate,
   output logic ramp_run,
   output logic ramp_restart_stb,
   output logic [PAR_W-1:0] tone_freq,
   output logic [PAR_W-1:0] gain_scale
);
   typedef struct packed {
      logic busy;
      logic [AIDX_W-1:0] scan;
      logic [GRP_W-1:0] grp;
      logic [PAR_W-1:0] ph_off;
      logic bump_stb;
      logic force_stb;
      logic restart_stb;
      logic [PAR_W-1:0] bump;
      logic [PAR_W-1:0] force_val;
      logic [PAR_W-1:0] rate;
      logic run;
      logic [PAR_W-1:0] tone;
      logic [PAR_W-1:0] gain;
   } act_state_t;
   act_state_t s_r, s_nxt;
   act_t act_mem [ACT_DEPTH];
   act_t a;

   // host loads the action table
   always_ff @(posedge ref_clk) begin
      if (act_wr_en) act_mem[act_wr_addr] <= act_t'(act_wr_data);
   end

   // walk every row once per firing and execute each matching row
   always_comb begin
      s_nxt = s_r;
      s_nxt.bump_stb = 1'b0;
      s_nxt.force_stb = 1'b0;
      s_nxt.restart_stb = 1'b0;
      a = act_mem[s_r.scan];
      if (!s_r.busy && fire) begin
         s_nxt.busy = 1'b1;
         s_nxt.scan = '0;
         s_nxt.grp = fire_grp;
      end else if (s_r.busy) begin
         if (a.en && a.grp == s_r.grp) begin
            case (a.kind)
               ACT_PHASE_ADD: s_nxt.ph_off = a.param;
               ACT_PHASE_BUMP: begin
                  s_nxt.bump_stb = 1'b1;
                  s_nxt.bump = a.param;
               end
               ACT_PHASE_FORCE: begin
                  s_nxt.force_stb = 1'b1;
                  s_nxt.force_val = a.param;
               end
               ACT_RAMP_RATE: s_nxt.rate = a.param;
               ACT_RAMP_GO: s_nxt.run = 1'b1;
               ACT_RAMP_STOP: s_nxt.run = 1'b0;
               ACT_RAMP_RESTART: begin
                  s_nxt.restart_stb = 1'b1;
                  s_nxt.run = 1'b1;
               end
               ACT_TONE_SET: s_nxt.tone = a.param;
               ACT_GAIN_SET: s_nxt.gain = a.param;
               default: s_nxt.run = s_r.run;
            endcase
         end
         if (s_r.scan == AIDX_W'(ACT_DEPTH - 1)) s_nxt.busy = 1'b0;
         else s_nxt.scan = s_r.scan + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) s_r <= '0;
      else s_r <= s_nxt;
   end

   assign busy = s_r.busy;
   assign phase_offset = s_r.ph_off;
   assign phase_bump_stb = s_r.bump_stb;
   assign phase_bump = s_r.bump;
   assign phase_force_stb = s_r.force_stb;
   assign phase_force = s_r.force_val;
   assign ramp_rate = s_r.rate;
   assign ramp_run = s_r.run;
   assign ramp_restart_stb = s_r.restart_stb;
   assign tone_freq = s_r.tone;
   assign gain_scale = s_r.gain;
endmodule : seq_action_unit

// ===== src/segment_sequence_player.sv
`timescale 1ns/1ns
// Functional notes
// - auto mode: after all loops move to next entry without any event
// - conditional mode: replay until event, then finish pass and move on
// - repeat mode: after loops hold last sample, next entry on event
// - single mode: one pass, hold, one more pass per event, then move on
// - auto, conditional, repeat also apply per sequence with sequence loops
// - single mode per sequence: one sequence pass per event until count done
// - a data entry plays its segment loop count passes before advancing
// - start and end offsets pick part of a segment; loader keeps granularity
// - entry after an empty entry starts a new sequence
// - config entry plays samples once, links an action group, interpolated only
// - idle entry emits a constant sample for a delay with a minimum length
// - amplitude init flag points to index zero and applies it at once
// - amplitude next flag steps pointer by one and applies it at once
// - frequency init or next flag sets pointer and loads oscillator frequency
// - table stepping follows only the entry flag, no sample marker
// - config actions fire at the next sample marker of a later segment
// - every action under one group identifier runs when the group fires
// - phase add action offsets output phase, accumulator untouched
// - phase bump alters the accumulator; phase force sets absolute phase
// - ramp actions set rate, start, stop, or restart from last start
// - tone and gain actions set carrier frequency and amplitude scale
module segment_sequence_player import seq_pkg::*; #(
   parameter int DEPTH = 64,
   parameter int IDX_W = $clog2(DEPTH),
   parameter int ACT_DEPTH = 16,
   parameter int AIDX_W = $clog2(ACT_DEPTH)
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic interp_mode,
   input wire logic adv_event,
   input wire logic [IDX_W:0] num_entries,
   input wire logic tbl_wr_en,
   input wire logic [IDX_W-1:0] tbl_wr_addr,
   input wire logic [ENTRY_W-1:0] tbl_wr_data,
   input wire logic amp_wr_en,
   input wire logic [PTR_W-1:0] amp_wr_addr,
   input wire logic [AMP_W-1:0] amp_wr_data,
   input wire logic freq_wr_en,
   input wire logic [PTR_W-1:0] freq_wr_addr,
   input wire logic [PAR_W-1:0] freq_wr_data,
   input wire logic act_wr_en,
   input wire logic [AIDX_W-1:0] act_wr_addr,
   input wire logic [ACT_W-1:0] act_wr_data,
   output logic [ADDR_W-1:0] mem_addr,
   input wire logic [SAMP_W-1:0] mem_rdata,
   input wire logic mem_marker,
   output logic out_valid,
   input wire logic out_ready,
   output logic [SAMP_W-1:0] out_data,
   output logic [AMP_W-1:0] amp_scale,
   output logic [PAR_W-1:0] nco_freq,
   output logic [IDX_W-1:0] entry_index,
   output logic playing,
   output logic holding,
   output logic action_busy,
   output logic [PAR_W-1:0] phase_offset,
   output logic phase_bump_stb,
   output logic [PAR_W-1:0] phase_bump,
   output logic phase_force_stb,
   output logic [PAR_W-1:0] phase_force,
   output logic [PAR_W-1:0] ramp_rate,
   output logic ramp_run,
   output logic ramp_restart_stb,
   output logic [PAR_W-1:0] tone_freq,
   output logic [PAR_W-1:0] gain_scale
);
   typedef enum logic [2:0] {S_STOP, S_FETCH, S_PLAY, S_IDLE, S_HOLD} pl_st_t;

   typedef struct packed {
      pl_st_t st;
      entry_t cur;
      logic [IDX_W-1:0] idx;
      logic [IDX_W-1:0] seq_start;
      logic new_seq;
      logic [CNT_W-1:0] seg_cnt;
      logic [CNT_W-1:0] seq_cnt;
      adv_t seq_adv;
      logic [ADDR_W-1:0] pos;
      logic hold_seq;
      logic hold_next;
      logic ev_s1;
      logic ev_s2;
      logic ev_s3;
      logic ev_pend;
      logic [PTR_W-1:0] amp_ptr;
      logic [PTR_W-1:0] freq_ptr;
      logic [AMP_W-1:0] amp_val;
      logic [PAR_W-1:0] freq_val;
      logic act_pend;
      logic [GRP_W-1:0] act_grp;
      logic act_live;
      logic [GRP_W-1:0] live_grp;
      logic fire;
      logic [GRP_W-1:0] fire_grp;
      logic [SAMP_W-1:0] last;
   } pl_state_t;

   pl_state_t s_r, s_nxt;
   entry_t entry_mem [DEPTH];
   logic [AMP_W-1:0] amp_mem [2**PTR_W];
   logic [PAR_W-1:0] freq_mem [2**PTR_W];

   entry_t fe, ne;
   dec_res_t d, q;
   logic [IDX_W:0] idx_p1;
   logic [IDX_W-1:0] nidx;
   logic last_in_seq, ev_edge, ev_left, consume;
   logic pass_end, go_entry, go_seq, replay_seq, replay_entry;
   logic push, buf_in_ready;
   logic [SAMP_W-1:0] push_data;

   // first sample position of a pass, or the pause length of an idle entry
   function automatic logic [ADDR_W-1:0] start_pos(entry_t e);
      logic [ADDR_W-1:0] p;
      p = ADDR_W'(e.seg_addr + e.start_off);
      if (e.etype == ET_IDLE) begin
         p = (e.idle_delay > IDLE_MIN_LEN) ? e.idle_delay : IDLE_MIN_LEN;
      end
      return p;
   endfunction : start_pos

   // playing state that an entry uses
   function automatic pl_st_t play_state(entry_t e);
      return (e.etype == ET_IDLE) ? S_IDLE : S_PLAY;
   endfunction : play_state

   // host loads sequence, amplitude and frequency tables
   always_ff @(posedge ref_clk) begin
      if (tbl_wr_en) entry_mem[tbl_wr_addr] <= entry_t'(tbl_wr_data);
      if (amp_wr_en) amp_mem[amp_wr_addr] <= amp_wr_data;
      if (freq_wr_en) freq_mem[freq_wr_addr] <= freq_wr_data;
   end

   // sequencer next-state logic
   always_comb begin
      s_nxt = s_r;
      // the advance event is a pin: two flops, then edge detect on the second
      s_nxt.ev_s1 = adv_event;
      s_nxt.ev_s2 = s_r.ev_s1;
      s_nxt.ev_s3 = s_r.ev_s2;
      ev_edge = s_r.ev_s2 & ~s_r.ev_s3;
      consume = 1'b0;
      push = 1'b0;
      push_data = s_r.last;
      pass_end = 1'b0;
      go_entry = 1'b0;
      go_seq = 1'b0;
      replay_seq = 1'b0;
      replay_entry = 1'b0;
      s_nxt.fire = 1'b0;
      d = adv_decide(s_r.cur.seg_adv, s_r.seg_cnt, s_r.ev_pend);
      q = adv_decide(s_r.seq_adv, s_r.seq_cnt, 1'b0);
      ev_left = s_r.ev_pend;
      // neighbour entry decides whether this one closes its sequence
      idx_p1 = {1'b0, s_r.idx} + {{IDX_W{1'b0}}, 1'b1};
      nidx = (idx_p1 >= num_entries) ? '0 : idx_p1[IDX_W-1:0];
      fe = entry_mem[s_r.idx];
      ne = entry_mem[nidx];
      last_in_seq = (nidx == '0) || ne.new_seq || (ne.etype == ET_EMPTY);

      case (s_r.st)
         S_STOP: begin
            if (run && num_entries != '0) begin
               s_nxt.idx = '0;
               s_nxt.new_seq = 1'b1;
               s_nxt.st = S_FETCH;
            end
         end
         S_FETCH: begin
            if (fe.etype == ET_EMPTY) begin
               s_nxt.idx = nidx;
               s_nxt.new_seq = 1'b1;
            end else begin
               s_nxt.cur = fe;
               // data entries loop; config and idle entries play one pass
               s_nxt.seg_cnt = (fe.etype == ET_DATA) ? fe.seg_loop : CNT_ONE;
               if (s_r.new_seq) begin
                  s_nxt.seq_start = s_r.idx;
                  s_nxt.seq_cnt = fe.seq_loop;
                  s_nxt.seq_adv = fe.seq_adv;
                  s_nxt.new_seq = 1'b0;
               end
               s_nxt.pos = start_pos(fe);
               s_nxt.st = play_state(fe);
               // table pointers step on the entry flag alone
               if (fe.amp_init) begin
                  s_nxt.amp_ptr = '0;
                  s_nxt.amp_val = amp_mem['0];
               end else if (fe.amp_next) begin
                  s_nxt.amp_ptr = s_r.amp_ptr + 1'b1;
                  s_nxt.amp_val = amp_mem[s_r.amp_ptr + 1'b1];
               end
               if (fe.freq_init) begin
                  s_nxt.freq_ptr = '0;
                  s_nxt.freq_val = freq_mem['0];
               end else if (fe.freq_next) begin
                  s_nxt.freq_ptr = s_r.freq_ptr + 1'b1;
                  s_nxt.freq_val = freq_mem[s_r.freq_ptr + 1'b1];
               end
               // an armed group goes live once a later entry starts
               if (s_r.act_pend) begin
                  s_nxt.act_pend = 1'b0;
                  s_nxt.act_live = 1'b1;
                  s_nxt.live_grp = s_r.act_grp;
               end
               if (fe.etype == ET_CONFIG && interp_mode) begin
                  s_nxt.act_pend = 1'b1;
                  s_nxt.act_grp = fe.action_group_id;
               end
            end
         end
         S_PLAY: begin
            if (buf_in_ready) begin
               push = 1'b1;
               push_data = mem_rdata;
               s_nxt.last = mem_rdata;
               if (s_r.act_live && mem_marker) begin
                  s_nxt.fire = 1'b1;
                  s_nxt.fire_grp = s_r.live_grp;
                  s_nxt.act_live = 1'b0;
               end
               if (s_r.pos == ADDR_W'(s_r.cur.seg_addr + s_r.cur.end_off)) pass_end = 1'b1;
               else s_nxt.pos = s_r.pos + 1'b1;
            end
         end
         S_IDLE: begin
            if (buf_in_ready) begin
               push = 1'b1;
               push_data = s_r.cur.idle_sample;
               s_nxt.last = s_r.cur.idle_sample;
               if (s_r.pos <= CNT_ONE) pass_end = 1'b1;
               else s_nxt.pos = s_r.pos - 1'b1;
            end
         end
         S_HOLD: begin
            // keep the last sample flowing while waiting
            push = buf_in_ready;
            if (s_r.ev_pend) begin
               consume = 1'b1;
               ev_left = 1'b0;
               if (s_r.hold_seq) begin
                  go_seq = s_r.hold_next;
                  replay_seq = ~s_r.hold_next;
               end else begin
                  go_entry = s_r.hold_next;
                  replay_entry = ~s_r.hold_next;
               end
            end
         end
         default: s_nxt.st = S_STOP;
      endcase

      // end of one pass of the current entry
      if (pass_end) begin
         s_nxt.seg_cnt = d.left;
         consume = d.used;
         ev_left = s_r.ev_pend & ~d.used;
         case (d.dec)
            DEC_REPLAY: replay_entry = 1'b1;
            DEC_WAIT_REPLAY: begin
               s_nxt.st = S_HOLD;
               s_nxt.hold_seq = 1'b0;
               s_nxt.hold_next = 1'b0;
            end
            DEC_WAIT_NEXT: begin
               s_nxt.st = S_HOLD;
               s_nxt.hold_seq = 1'b0;
               s_nxt.hold_next = 1'b1;
            end
            default: go_entry = 1'b1;
         endcase
      end

      if (replay_entry) begin
         s_nxt.pos = start_pos(s_r.cur);
         s_nxt.st = play_state(s_r.cur);
      end

      // leaving an entry: the last one of a sequence ends a sequence pass
      if (go_entry) begin
         if (last_in_seq) begin
            q = adv_decide(s_r.seq_adv, s_r.seq_cnt, ev_left);
            s_nxt.seq_cnt = q.left;
            consume = consume | q.used;
            case (q.dec)
               DEC_REPLAY: replay_seq = 1'b1;
               DEC_WAIT_REPLAY: begin
                  s_nxt.st = S_HOLD;
                  s_nxt.hold_seq = 1'b1;
                  s_nxt.hold_next = 1'b0;
               end
               DEC_WAIT_NEXT: begin
                  s_nxt.st = S_HOLD;
                  s_nxt.hold_seq = 1'b1;
                  s_nxt.hold_next = 1'b1;
               end
               default: go_seq = 1'b1;
            endcase
         end else begin
            s_nxt.idx = nidx;
            s_nxt.st = S_FETCH;
         end
      end

      // sequence replay keeps its counter; a new sequence reloads it
      if (replay_seq) begin
         s_nxt.idx = s_r.seq_start;
         s_nxt.st = S_FETCH;
      end
      if (go_seq) begin
         s_nxt.idx = nidx;
         s_nxt.new_seq = 1'b1;
         s_nxt.st = S_FETCH;
      end

      // a new edge wins over a consume in the same cycle
      s_nxt.ev_pend = (s_r.ev_pend & ~consume) | ev_edge;
      if (!run) s_nxt.st = S_STOP;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) s_r <= '0;
      else s_r <= s_nxt;
   end

   // output stream buffer; a full buffer stalls the play and idle states
   seq_out_buffer #(.W(SAMP_W)) u_buf (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_valid(push),
      .in_ready(buf_in_ready),
      .in_data(push_data),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data)
   );

   // oscillator actions of configuration entries
   seq_action_unit #(.ACT_DEPTH(ACT_DEPTH), .AIDX_W(AIDX_W)) u_act (
      .ref_clk(ref_clk),
      .rst(rst),
      .fire(s_r.fire),
      .fire_grp(s_r.fire_grp),
      .act_wr_en(act_wr_en),
      .act_wr_addr(act_wr_addr),
      .act_wr_data(act_wr_data),
      .busy(action_busy),
      .phase_offset(phase_offset),
      .phase_bump_stb(phase_bump_stb),
      .phase_bump(phase_bump),
      .phase_force_stb(phase_force_stb),
      .phase_force(phase_force),
      .ramp_rate(ramp_rate),
      .ramp_run(ramp_run),
      .ramp_restart_stb(ramp_restart_stb),
      .tone_freq(tone_freq),
      .gain_scale(gain_scale)
   );

   // status and table outputs straight from state
   assign mem_addr = s_r.pos;
   assign amp_scale = s_r.amp_val;
   assign nco_freq = s_r.freq_val;
   assign entry_index = s_r.idx;
   assign playing = (s_r.st == S_PLAY) || (s_r.st == S_IDLE);
   assign holding = (s_r.st == S_HOLD);
endmodule : segment_sequence_player

// ===== sim/seg_player_monitor.sv
`timescale 1ns/1ns
module seg_player_monitor import seq_pkg::*; #(
   parameter int IDX_W = 6,
   parameter int ACT_DEPTH = 16
) (
   input logic ref_clk,
   input logic rst,
   input logic run,
   input logic out_valid,
   input logic out_ready,
   input logic [SAMP_W-1:0] out_data,
   input logic playing,
   input logic action_busy,
   input logic [IDX_W-1:0] entry_index,
   input logic [AMP_W-1:0] amp_scale,
   input logic [PAR_W-1:0] nco_freq
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [7:0] busy_len_r;
   // length of the running action scan
   always_ff @(posedge ref_clk) busy_len_r <= (rst || !action_busy) ? 8'h00 : busy_len_r + 8'h01;
   a_reset_quiet: assert property (disable iff (1'b0)
      rst |=> !out_valid && !playing)
      else $error("outputs active after reset");
   a_stall_valid: assert property (out_valid && !out_ready |=> out_valid)
      else $error("sample dropped under stall");
   a_stall_data: assert property (out_valid && !out_ready |=> $stable(out_data))
      else $error("sample changed under stall");
   a_start_play: assert property ($rose(run) ##1 run[*2] |-> playing ##1 out_valid)
      else $error("late start of playback");
   a_stop_quick: assert property (!run |=> !playing)
      else $error("still playing after stop");
   // one firing keeps the scan busy for exactly one cycle per action row
   a_busy_scan: assert property ($fell(action_busy) |-> busy_len_r == ACT_DEPTH)
      else $error("action scan length wrong");
   a_index_fetch: assert property ($changed(entry_index) |-> !playing)
      else $error("index moved during playback");
   a_table_step: assert property ($changed({amp_scale, nco_freq}) |->
      !$past(playing))
      else $error("table step outside fetch");
   c_scan_done: cover property ($fell(action_busy));
   c_stall: cover property (out_valid && !out_ready);
   c_play: cover property ($rose(playing));
endmodule : seg_player_monitor

bind segment_sequence_player seg_player_monitor #(.IDX_W(IDX_W), .ACT_DEPTH(ACT_DEPTH)) mon (
   .ref_clk, .rst, .run, .out_valid, .out_ready, .out_data, .playing, .action_busy,
   .entry_index, .amp_scale, .nco_freq);

// ===== sim/sample_mem_model.sv
`timescale 1ns/1ns
module sample_mem_model import seq_pkg::*; (
   input logic [ADDR_W-1:0] mem_addr,
   output logic [SAMP_W-1:0] mem_rdata,
   output logic mem_marker
);
   // stored samples: address mixed with a fixed pattern, read at once
   assign mem_rdata = mem_addr ^ 16'h5A00;
   // sample marker wherever the low nibble is three
   assign mem_marker = mem_addr[3:0] == 4'h3;
endmodule : sample_mem_model

// ===== sim/tb_top.sv
`timescale 1ns/1ns
module tb_top import seq_pkg::*; ;
   logic ref_clk = 0, rst = 1, run = 0, adv_event = 0, out_ready = 0, mem_marker;
   logic tbl_wr_en = 0, amp_wr_en = 0, freq_wr_en = 0, act_wr_en = 0, out_valid, playing, holding;
   logic [5:0] tbl_wr_addr = '0;
   logic [4:0] amp_wr_addr = '0, freq_wr_addr = '0;
   logic [3:0] act_wr_addr = '0;
   logic [ENTRY_W-1:0] tbl_wr_data = '0;
   logic [ACT_W-1:0] act_wr_data = '0;
   logic [15:0] amp_wr_data = '0, amp_scale, mem_addr, mem_rdata, out_data, last, amp_tab [16];
   logic [31:0] freq_wr_data = '0, nco_freq, tone_freq, gain_scale, freq_tab [16], prm [16];
   logic [15:0] q [$];
   int errors = 0, samples_checked = 0, seed = 27828, cyc = 0;

   segment_sequence_player dut (.ref_clk, .rst, .run, .interp_mode(1'b1), .adv_event,
      .num_entries(7'h07), .tbl_wr_en, .tbl_wr_addr, .tbl_wr_data, .amp_wr_en, .amp_wr_addr,
      .amp_wr_data, .freq_wr_en, .freq_wr_addr, .freq_wr_data, .act_wr_en, .act_wr_addr,
      .act_wr_data, .mem_addr, .mem_rdata, .mem_marker, .out_valid, .out_ready, .out_data,
      .amp_scale, .nco_freq, .entry_index(), .playing, .holding, .action_busy(),
      .phase_offset(), .phase_bump_stb(), .phase_bump(), .phase_force_stb(), .phase_force(),
      .ramp_rate(), .ramp_run(), .ramp_restart_stb(), .tone_freq, .gain_scale);
   sample_mem_model mem (.mem_addr, .mem_rdata, .mem_marker);

   // 125 MHz clock
   always #4 ref_clk = ~ref_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   // one table entry; flags are amp init, amp next, freq init, freq next
   task automatic ent(input int i, etype_t t, adv_t m, adv_t sm, logic [3:0] fl,
         input int a, s, e, n, sn);
      entry_t x;
      x = '0;
      x.etype = t;
      x.seg_adv = m;
      x.seq_adv = sm;
      {x.amp_init, x.amp_next, x.freq_init, x.freq_next} = fl;
      x.seg_addr = 16'(a);
      x.start_off = 16'(s);
      x.end_off = 16'(e);
      x.seg_loop = 16'(n);
      x.seq_loop = 16'(sn);
      x.action_group_id = 4'h3;
      x.idle_delay = 16'h0003;
      x.idle_sample = 16'h7777;
      @(negedge ref_clk);
      tbl_wr_en = 1;
      tbl_wr_addr = 6'(i);
      tbl_wr_data = x;
      @(negedge ref_clk);
      tbl_wr_en = 0;
   endtask : ent

   // model: one pass of a segment between its offsets
   task automatic pass(input int a, s, e);
      for (int i = s; i <= e; i++) q.push_back(16'(a + i) ^ 16'h5A00);
   endtask : pass

   task automatic pulse();
      adv_event = 1;
      repeat (4) @(negedge ref_clk);
      adv_event = 0;
      repeat (6) @(negedge ref_clk);
   endtask : pulse

   // random stall, then compare each new value the buffer hands over
   always @(negedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
      out_ready = ($random(seed) & 3) != 0;
      if (!rst && out_valid && out_ready && out_data !== last && q.size() > 0) begin
         last = out_data;
         chk(out_data, q.pop_front());
         if (out_data === 16'h7777) begin
            chk(amp_scale, amp_tab[1]);
            chk(nco_freq, freq_tab[1]);
            chk(tone_freq, prm[0]);
            chk(gain_scale, prm[5]);
         end
      end
   end

   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 0;
      for (int k = 0; k < 16; k++) begin
         @(negedge ref_clk);
         amp_tab[k] = 16'($random(seed));
         freq_tab[k] = $random(seed);
         prm[k] = $random(seed);
         {amp_wr_en, freq_wr_en, act_wr_en} = 3'h7;
         {amp_wr_addr, freq_wr_addr, act_wr_addr} = {5'(k), 5'(k), 4'(k)};
         {amp_wr_data, freq_wr_data} = {amp_tab[k], freq_tab[k]};
         act_wr_data = {k == 0 || k == 5 || k == 7, k == 7 ? 4'h2 : 4'h3,
            k == 5 ? ACT_GAIN_SET : ACT_TONE_SET, prm[k]};
      end
      @(negedge ref_clk);
      {amp_wr_en, freq_wr_en, act_wr_en} = 3'h0;
      // first sequence ends in a sequence-level repeat hold after the idle entry
      ent(0, ET_DATA, ADV_AUTO, ADV_REPEAT, 4'hA, 'h10, 0, 3, 2, 1);
      ent(1, ET_CONFIG, ADV_COND, ADV_AUTO, 4'h0, 'h20, 1, 2, 1, 1);
      ent(2, ET_DATA, ADV_REPEAT, ADV_AUTO, 4'h4, 'h30, 2, 4, 2, 1);
      ent(3, ET_DATA, ADV_SINGLE, ADV_AUTO, 4'h1, 'h40, 0, 2, 2, 1);
      ent(4, ET_IDLE, ADV_AUTO, ADV_AUTO, 4'h0, 0, 0, 0, 1, 1);
      ent(5, ET_EMPTY, ADV_AUTO, ADV_AUTO, 4'h0, 0, 0, 0, 1, 1);
      ent(6, ET_DATA, ADV_AUTO, ADV_SINGLE, 4'h0, 'h60, 0, 1, 1, 2);
      for (int k = 0; k < 2; k++) pass('h10, 0, 3);
      pass('h20, 1, 2);
      for (int k = 0; k < 2; k++) pass('h30, 2, 4);
      for (int k = 0; k < 2; k++) pass('h40, 0, 2);
      q.push_back(16'h7777);
      for (int k = 0; k < 2; k++) pass('h60, 0, 1);
      run = 1;
      repeat (2) @(negedge ref_clk);
      pulse(); // early event, kept for the conditional entry
      while (q.size() > 0) begin
         @(negedge ref_clk);
         if (holding) pulse();
      end
      run = 0;
      repeat (3) @(negedge ref_clk);
      chk(playing, 1'b0);
      end_sim();
   end
endmodule : tb_top
